// ### hdl/tmc_top.sv
// Functional notes
// - Alignment 00 counts edge-aligned, direction from the direction bit.
// - Alignment 01 counts up/down; compare flag set only counting down.
// - Alignment 10 counts up/down; compare flag set only counting up.
// - Alignment 11 counts up/down; compare flag set in both directions.
// - Edge mode: direction 0 increments, direction 1 decrements.
// - Direction bit ignored in centre-aligned and encoder modes.
// - Single-pulse clears the run bit at next update event.
// - Update source 1: only overflow/underflow raises update interrupt.
// - Update source 0: overflow, soft trigger or slave update raise interrupt.
// - Update disable blocks update events; shadow registers hold.
// - Soft trigger or slave reset still reinitialise counter and prescaler.
// - Updates come from overflow, soft trigger, slave; they load shadows.
// - Run bit starts the counter at 1, halts it at 0.
// - Encoder mode waits for software run bit.
// - Trigger slave mode sets the run bit in hardware on trigger.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module tmc_top #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // AXI4-Lite write address
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Slave mode controller inputs, same clock
  input  wire logic          slave_update,
  input  wire logic          slave_reset,
  input  wire logic          slave_trigger,
  // Encoder pins
  input  wire logic          enc_step_pin,
  input  wire logic          enc_up_pin,
  // Outputs
  output logic               irq_ff,
  output logic               update_pulse_ff
);
  import tmc_pkg::*;

  // Bus state
  logic [7:0]    aw_addr_ff;
  logic          aw_have_ff;
  logic [31:0]   w_data_ff;
  logic [3:0]    w_strb_ff;
  logic          w_have_ff;
  logic          do_write;
  // Registers
  logic [15:0]   ctrl_ff;
  logic [2:0]    slave_cfg_ff;
  logic [W-1:0]  reload_pre_ff;
  logic [W-1:0]  prescaler_pre_ff;
  logic [W-1:0]  compare_pre_ff;
  logic [TMC_ST_W-1:0] status_ff;
  logic [TMC_ST_W-1:0] irq_en_ff;
  logic          soft_ug_ff;
  // Pin synchronisers
  logic [1:0]    step_sync_ff;
  logic [1:0]    up_sync_ff;
  logic          step_last_ff;
  // Core
  tmc_ctrl_type  ctrl;
  tmc_event_type evt;
  logic [W-1:0]  count;
  logic [W-1:0]  reload_value;
  logic [W-1:0]  prescaler_value;
  logic          down_state;
  logic          trig_start;
  logic [31:0]   nxt_rdata;
  logic          nxt_rerr;
  logic [15:0]   wd16;

  assign wd16 = {w_strb_ff[1] ? w_data_ff[15:8] : 8'h00,
                 w_strb_ff[0] ? w_data_ff[7:0]  : 8'h00};
  assign do_write = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  // Trigger mode start, only when trigger mode selected
  assign trig_start = slave_cfg_ff[TMC_BIT_TRIG] & slave_trigger & ~ctrl_ff[TMC_BIT_RUN];

  // Control fields toward the core
  always_comb begin
    ctrl.align_mode_sel    = tmc_align_type'(ctrl_ff[TMC_BIT_ALIGN_H:TMC_BIT_ALIGN_L]);
    ctrl.count_down        = ctrl_ff[TMC_BIT_DIR];
    ctrl.single_pulse      = ctrl_ff[TMC_BIT_SINGLE];
    ctrl.update_source_sel = ctrl_ff[TMC_BIT_USRC];
    ctrl.update_disable    = ctrl_ff[TMC_BIT_UPDATE_DISABLE];
    ctrl.counter_run       = ctrl_ff[TMC_BIT_RUN];
  end

  // Write address and data capture in either order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_ff & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_have_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_have_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_ff <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TMC_RESP_OK;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_ff > TMC_OFS_COMPARE || aw_addr_ff[1:0] != 2'b00) ?
                      TMC_RESP_ERR : TMC_RESP_OK;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register: software writes, single-pulse stop, trigger start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= TMC_CTRL_RST;
    end else if (do_write && aw_addr_ff == TMC_OFS_CTRL) begin
      ctrl_ff <= wd16 & TMC_CTRL_MASK;
    end else if (evt.single_stop) begin
      ctrl_ff[TMC_BIT_RUN] <= 1'b0;
    end else if (trig_start) begin
      ctrl_ff[TMC_BIT_RUN] <= 1'b1;
    end
  end

  // Configuration and preload registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slave_cfg_ff     <= 3'h0;
      reload_pre_ff    <= '0;
      prescaler_pre_ff <= '0;
      compare_pre_ff   <= '0;
      irq_en_ff        <= '0;
    end else if (do_write) begin
      unique case (aw_addr_ff)
        TMC_OFS_SLAVE:    slave_cfg_ff     <= wd16[2:0];
        TMC_OFS_RELOAD:   reload_pre_ff    <= wd16[W-1:0];
        TMC_OFS_PRESCALE: prescaler_pre_ff <= wd16[W-1:0];
        TMC_OFS_COMPARE:  compare_pre_ff   <= wd16[W-1:0];
        TMC_OFS_IRQ_EN:   irq_en_ff        <= wd16[TMC_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Software update trigger, one-cycle pulse, self clearing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_ug_ff <= 1'b0;
    end else begin
      soft_ug_ff <= do_write && aw_addr_ff == TMC_OFS_EVGEN && wd16[0];
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~((do_write && aw_addr_ff == TMC_OFS_IRQ_CLR) ?
                                  wd16[TMC_ST_W-1:0] : '0))
                   | {trig_start, evt.compare_hit, evt.update_irq};
    end
  end

  // Interrupt and update outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ff          <= 1'b0;
      update_pulse_ff <= 1'b0;
    end else begin
      irq_ff          <= |(status_ff & irq_en_ff);
      update_pulse_ff <= evt.update_irq;
    end
  end

  // Encoder pin synchronisers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_sync_ff <= 2'b00;
      up_sync_ff   <= 2'b00;
      step_last_ff <= 1'b0;
    end else begin
      step_sync_ff <= {step_sync_ff[0], enc_step_pin};
      up_sync_ff   <= {up_sync_ff[0], enc_up_pin};
      step_last_ff <= step_sync_ff[1];
    end
  end

  // Read data mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rerr  = 1'b0;
    unique case (s_axi_araddr)
      TMC_OFS_CTRL:     nxt_rdata[15:0] = ctrl_ff;
      TMC_OFS_SLAVE:    nxt_rdata[2:0]  = slave_cfg_ff;
      TMC_OFS_RELOAD:   nxt_rdata[W-1:0] = reload_pre_ff;
      TMC_OFS_PRESCALE: nxt_rdata[W-1:0] = prescaler_pre_ff;
      TMC_OFS_COUNT:    nxt_rdata[W-1:0] = count;
      TMC_OFS_STATUS:   nxt_rdata[TMC_ST_W:0] = {down_state, status_ff};
      TMC_OFS_IRQ_EN:   nxt_rdata[TMC_ST_W-1:0] = irq_en_ff;
      TMC_OFS_IRQ_CLR:  nxt_rdata = 32'h0000_0000;
      TMC_OFS_EVGEN:    nxt_rdata = 32'h0000_0000;
      TMC_OFS_COMPARE:  nxt_rdata[W-1:0] = compare_pre_ff;
      default:          nxt_rerr = 1'b1;
    endcase
  end

  // Read channel
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= TMC_RESP_OK;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= nxt_rdata;
        s_axi_rresp  <= nxt_rerr ? TMC_RESP_ERR : TMC_RESP_OK;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Counter core
  tmc_core #(
    .W(W)
  ) u_core (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .ctrl                (ctrl),
    .encoder_mode        (slave_cfg_ff[TMC_BIT_ENC]),
    .ext_step            (step_sync_ff[1] & ~step_last_ff),
    .ext_up              (up_sync_ff[1]),
    .soft_update_trigger (soft_ug_ff),
    .slave_update        (slave_update),
    .slave_reset         (slave_reset),
    .compare_output      (slave_cfg_ff[TMC_BIT_OUTCH]),
    .reload_pre          (reload_pre_ff),
    .prescaler_pre       (prescaler_pre_ff),
    .compare_pre         (compare_pre_ff),
    .count_ff            (count),
    .reload_value_ff     (reload_value),
    .prescaler_value_ff  (prescaler_value),
    .down_ff             (down_state),
    .evt_ff              (evt)
  );

endmodule

// ### hdl/tmc_pkg.sv
package tmc_pkg;

  // Register byte offsets
  localparam logic [7:0] TMC_OFS_CTRL     = 8'h00;
  localparam logic [7:0] TMC_OFS_SLAVE    = 8'h04;
  localparam logic [7:0] TMC_OFS_RELOAD   = 8'h08;
  localparam logic [7:0] TMC_OFS_PRESCALE = 8'h0C;
  localparam logic [7:0] TMC_OFS_COUNT    = 8'h10;
  localparam logic [7:0] TMC_OFS_STATUS   = 8'h14;
  localparam logic [7:0] TMC_OFS_IRQ_EN   = 8'h18;
  localparam logic [7:0] TMC_OFS_IRQ_CLR  = 8'h1C;
  localparam logic [7:0] TMC_OFS_EVGEN    = 8'h20;
  localparam logic [7:0] TMC_OFS_COMPARE  = 8'h24;

  // Control field positions
  localparam int TMC_BIT_RUN     = 0;
  localparam int TMC_BIT_UPDATE_DISABLE    = 1;
  localparam int TMC_BIT_USRC    = 2;
  localparam int TMC_BIT_SINGLE  = 3;
  localparam int TMC_BIT_DIR     = 4;
  localparam int TMC_BIT_ALIGN_L = 5;
  localparam int TMC_BIT_ALIGN_H = 6;

  // Slave register field positions
  localparam int TMC_BIT_ENC     = 0;
  localparam int TMC_BIT_TRIG    = 1;
  localparam int TMC_BIT_OUTCH   = 2;

  // Status bit positions
  localparam int TMC_ST_UPDATE   = 0;
  localparam int TMC_ST_COMPARE  = 1;
  localparam int TMC_ST_TRIGGER  = 2;
  localparam int TMC_ST_W        = 3;

  // Reset values and control register write mask
  localparam logic [15:0] TMC_CTRL_RST  = 16'h0000;
  localparam logic [15:0] TMC_WORD_RST  = 16'h0000;
  localparam logic [15:0] TMC_CTRL_MASK = 16'h007F;

  // Alignment modes
  typedef enum logic [1:0] {
    TMC_EDGE    = 2'b00,
    TMC_CENTER1 = 2'b01,
    TMC_CENTER2 = 2'b10,
    TMC_CENTER3 = 2'b11
  } tmc_align_type;

  // AXI response codes
  localparam logic [1:0] TMC_RESP_OK  = 2'b00;
  localparam logic [1:0] TMC_RESP_ERR = 2'b10;

  // Control fields as carried to the counter core
  typedef struct packed {
    tmc_align_type align_mode_sel;
    logic          count_down;
    logic          single_pulse;
    logic          update_source_sel;
    logic          update_disable;
    logic          counter_run;
  } tmc_ctrl_type;

  // Core events toward the register side
  typedef struct packed {
    logic update_irq;
    logic compare_hit;
    logic single_stop;
    logic trigger_start;
  } tmc_event_type;

endpackage

// ### hdl/tmc_core.sv
`timescale 1ns/1ps
module tmc_core #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Control
  input  wire tmc_pkg::tmc_ctrl_type  ctrl,
  input  wire logic                   encoder_mode,
  input  wire logic                   ext_step,
  input  wire logic                   ext_up,
  input  wire logic                   soft_update_trigger,
  input  wire logic                   slave_update,
  input  wire logic                   slave_reset,
  input  wire logic                   compare_output,
  // Preload values
  input  wire logic [W-1:0]           reload_pre,
  input  wire logic [W-1:0]           prescaler_pre,
  input  wire logic [W-1:0]           compare_pre,
  // State
  output logic      [W-1:0]           count_ff,
  output logic      [W-1:0]           reload_value_ff,
  output logic      [W-1:0]           prescaler_value_ff,
  output logic                        down_ff,
  output tmc_pkg::tmc_event_type      evt_ff
);
  import tmc_pkg::*;

  logic [W-1:0] psc_cnt_ff;
  logic [W-1:0] compare_ff;
  logic         tick;
  logic         hit_top;
  logic         hit_bot;
  logic         center;
  logic         eff_down;
  logic         ovf;
  logic         update_event;
  logic         reinit;

  assign center   = (ctrl.align_mode_sel != TMC_EDGE);
  // Direction bit ignored in centre and encoder modes
  assign eff_down = encoder_mode ? ~ext_up :
                    (center ? down_ff : ctrl.count_down);
  // Encoder steps only while enabled, internal ticks from prescaler
  assign tick     = ctrl.counter_run &
                    (encoder_mode ? ext_step : (psc_cnt_ff == prescaler_value_ff));
  assign hit_top  = (count_ff == reload_value_ff);
  assign hit_bot  = (count_ff == '0);
  assign ovf      = tick & (eff_down ? hit_bot : hit_top);
  assign reinit   = soft_update_trigger | slave_reset;
  // Update event sources, blocked by update disable
  assign update_event = ~ctrl.update_disable &
                        (ovf | soft_update_trigger | slave_update);

  // Prescaler counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      psc_cnt_ff <= '0;
    end else if (reinit || !ctrl.counter_run || tick) begin
      psc_cnt_ff <= '0;
    end else begin
      psc_cnt_ff <= psc_cnt_ff + 1'b1;
    end
  end

  // Main counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= '0;
    end else if (reinit) begin
      count_ff <= eff_down && !center ? reload_value_ff : '0;
    end else if (tick) begin
      if (center) begin
        if (!down_ff && hit_top) count_ff <= count_ff - 1'b1;
        else if (down_ff && hit_bot) count_ff <= count_ff + 1'b1;
        else if (down_ff) count_ff <= count_ff - 1'b1;
        else count_ff <= count_ff + 1'b1;
      end else if (eff_down) begin
        count_ff <= hit_bot ? reload_value_ff : count_ff - 1'b1;
      end else begin
        count_ff <= hit_top ? '0 : count_ff + 1'b1;
      end
    end
  end

  // Centre-aligned direction toggles at the ends
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      down_ff <= 1'b0;
    end else if (!center) begin
      down_ff <= ctrl.count_down;
    end else if (reinit) begin
      down_ff <= 1'b0;
    end else if (tick && !down_ff && hit_top) begin
      down_ff <= 1'b1;
    end else if (tick && down_ff && hit_bot) begin
      down_ff <= 1'b0;
    end
  end

  // Shadow registers load only on update events
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reload_value_ff    <= '0;
      prescaler_value_ff <= '0;
      compare_ff         <= '0;
    end else if (update_event) begin
      reload_value_ff    <= reload_pre;
      prescaler_value_ff <= prescaler_pre;
      compare_ff         <= compare_pre;
    end
  end

  // Event pulses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_ff <= '0;
    end else begin
      // Update request source filter
      evt_ff.update_irq  <= update_event &
                            (ctrl.update_source_sel ? ovf : 1'b1);
      // Compare flag qualified by alignment mode
      evt_ff.compare_hit <= compare_output && tick && count_ff == compare_ff &&
                            (ctrl.align_mode_sel == TMC_EDGE    ||
                             ctrl.align_mode_sel == TMC_CENTER3 ||
                            (ctrl.align_mode_sel == TMC_CENTER1 && down_ff) ||
                            (ctrl.align_mode_sel == TMC_CENTER2 && !down_ff));
      evt_ff.single_stop   <= update_event & ctrl.single_pulse & ctrl.counter_run;
      evt_ff.trigger_start <= 1'b0;
    end
  end

endmodule

// ### testbench/tmc_top_chk.sv
`timescale 1ns/1ps
module tmc_top_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Events and outputs
  input wire logic        slave_update,
  input wire logic        irq_ff,
  input wire logic        update_pulse_ff
);
  import tmc_pkg::*;
  logic [7:0]  waddr_ff;
  logic [31:0] wdat_ff;
  logic [1:0]  upd_cfg_ff;
  logic        bvalid_d_ff;

  // Copy of update source and disable bits as software wrote them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waddr_ff    <= 8'h00;
      wdat_ff     <= 32'h0;
      upd_cfg_ff  <= 2'h0;
      bvalid_d_ff <= 1'b0;
    end else begin
      bvalid_d_ff <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
        waddr_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        wdat_ff <= s_axi_wdata;
      if (s_axi_bvalid && !bvalid_d_ff && waddr_ff == TMC_OFS_CTRL)
        upd_cfg_ff <= wdat_ff[2:1];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_aw_ready_once: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  chk_b_after_both: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("no write response");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_b_code: assert property (s_axi_bvalid |-> s_axi_bresp ==
    ((waddr_ff > 8'h24 || waddr_ff[1:0] != 2'b00) ? TMC_RESP_ERR : TMC_RESP_OK))
    else $error("wrong write response code");
  chk_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_r_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_src_slave_upd: assert property (
    slave_update && upd_cfg_ff == 2'b00 |-> ##[1:4] update_pulse_ff)
    else $error("slave update gave no update request");
  chk_update_disable_quiet: assert property (
    upd_cfg_ff[0] && $past(upd_cfg_ff[0], 3) |-> !update_pulse_ff)
    else $error("update request while updates disabled");
  chk_reset_idle: assert property (
    $past(sys_rst) |-> !irq_ff && !update_pulse_ff && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");

  cover property (update_pulse_ff);
  cover property (irq_ff);
  cover property (s_axi_bvalid && s_axi_bresp == TMC_RESP_ERR);
endmodule

bind tmc_top tmc_top_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .slave_update(slave_update), .irq_ff(irq_ff), .update_pulse_ff(update_pulse_ff)
);

// ### testbench/tmc_top_bench.sv
`timescale 1ns/1ps
module tmc_top_bench;
  import tmc_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0, r_d, rdv;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [2:0]  slv = 3'h0;
  logic        e_stp = 1'b0, e_up = 1'b0;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq, upd;
  logic [1:0]  b_rs, r_rs, resp;
  logic [15:0] c1;
  int          fails = 0;
  int          total_checks = 0;

  // System clock
  always #12.5 clk = ~clk;

  tmc_top dut (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .slave_update(slv[0]), .slave_reset(slv[1]), .slave_trigger(slv[2]),
    .enc_step_pin(e_stp), .enc_up_pin(e_up), .irq_ff(irq), .update_pulse_ff(upd)
  );

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    aw_a <= a;
    aw_v <= 1'b1;
    w_d <= d;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (aw_rdy)
        aw_v <= 1'b0;
      if (w_rdy)
        w_v <= 1'b0;
      ad = ad | aw_rdy;
      wd = wd | w_rdy;
    end
    @(posedge clk);
    while (!b_v)
      @(posedge clk);
    resp = b_rs;
    b_r <= 1'b0;
  endtask

  // Bus read
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    @(posedge clk);
    while (!ar_rdy)
      @(posedge clk);
    ar_v <= 1'b0;
    @(posedge clk);
    while (!r_v)
      @(posedge clk);
    rdv = r_d;
    resp = r_rs;
    r_r <= 1'b0;
  endtask

  // One-cycle pulse on trigger, reset or update from the mode controller
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    slv <= v;
    @(posedge clk);
    slv <= 3'h0;
    repeat (4) @(posedge clk);
  endtask

  // Encoder steps, counting upward
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge clk);
      e_up <= 1'b1;
      e_stp <= 1'b1;
      repeat (4) @(posedge clk);
      e_stp <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic t_reset;
    rd(TMC_OFS_CTRL);
    check(rdv, 32'h0);
    wr(TMC_OFS_CTRL, 32'h7E);
    rd(TMC_OFS_CTRL);
    check(rdv, 32'h7E);
    wr(8'h30, 32'h1);
    check(32'(resp), 32'(TMC_RESP_ERR));
    rd(8'h31);
    check(rdv, 32'h0);
    check(32'(resp), 32'(TMC_RESP_ERR));
    wr(TMC_OFS_CTRL, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_edge;
    wr(TMC_OFS_RELOAD, 32'hFFF0);
    wr(TMC_OFS_EVGEN, 32'h1);
    wr(TMC_OFS_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    rd(TMC_OFS_COUNT);
    c1 = rdv[15:0];
    rd(TMC_OFS_COUNT);
    check(32'(rdv[15:0] > c1), 32'h1);
    wr(TMC_OFS_CTRL, 32'h0);
    rd(TMC_OFS_COUNT);
    c1 = rdv[15:0];
    rd(TMC_OFS_COUNT);
    check(32'(rdv[15:0]), 32'(c1));
    wr(TMC_OFS_CTRL, 32'h11);
    rd(TMC_OFS_COUNT);
    c1 = rdv[15:0];
    rd(TMC_OFS_COUNT);
    check(32'(rdv[15:0] < c1), 32'h1);
    wr(TMC_OFS_CTRL, 32'h0);
    $display("test edge done");
  endtask

  task automatic t_centre;
    wr(TMC_OFS_RELOAD, 32'h10);
    wr(TMC_OFS_COMPARE, 32'h8);
    wr(TMC_OFS_SLAVE, 32'h4);
    for (int m = 1; m < 4; m++) begin
      for (int d = 0; d < 2; d++) begin
        wr(TMC_OFS_CTRL, m << 5);
        wr(TMC_OFS_EVGEN, 32'h1);
        wr(TMC_OFS_IRQ_CLR, 32'h7);
        wr(TMC_OFS_CTRL, (m << 5) | (d << 4) | 1);
        repeat (8) @(posedge clk);
        wr(TMC_OFS_CTRL, (m << 5) | (d << 4));
        rd(TMC_OFS_COUNT);
        if (d == 0)
          c1 = rdv[15:0];
        else
          check(32'(rdv[15:0]), 32'(c1));
        rd(TMC_OFS_STATUS);
        check(32'(rdv[1]), 32'(m != 1));
      end
    end
    $display("test centre done");
  endtask

  task automatic t_update;
    wr(TMC_OFS_CTRL, 32'h0);
    wr(TMC_OFS_IRQ_EN, 32'h1);
    wr(TMC_OFS_IRQ_CLR, 32'h7);
    pulse(3'b001);
    rd(TMC_OFS_STATUS);
    check(32'(rdv[0]), 32'h1);
    check(32'(irq), 32'h1);
    wr(TMC_OFS_IRQ_EN, 32'h0);
    @(posedge clk);
    check(32'(irq), 32'h0);
    wr(TMC_OFS_IRQ_EN, 32'h1);
    wr(TMC_OFS_IRQ_CLR, 32'h1);
    @(posedge clk);
    check(32'(irq), 32'h0);
    wr(TMC_OFS_EVGEN, 32'h1);
    rd(TMC_OFS_STATUS);
    check(32'(rdv[0]), 32'h1);
    wr(TMC_OFS_CTRL, 32'h4);
    wr(TMC_OFS_IRQ_CLR, 32'h7);
    pulse(3'b001);
    wr(TMC_OFS_EVGEN, 32'h1);
    rd(TMC_OFS_STATUS);
    check(32'(rdv[0]), 32'h0);
    wr(TMC_OFS_CTRL, 32'h5);
    repeat (40) @(posedge clk);
    wr(TMC_OFS_CTRL, 32'h4);
    rd(TMC_OFS_STATUS);
    check(32'(rdv[0]), 32'h1);
    wr(TMC_OFS_CTRL, 32'h2);
    wr(TMC_OFS_IRQ_CLR, 32'h7);
    for (int k = 0; k < 2; k++) begin
      wr(TMC_OFS_CTRL, 32'h3);
      repeat (3) @(posedge clk);
      wr(TMC_OFS_CTRL, 32'h2);
      if (k == 0)
        wr(TMC_OFS_EVGEN, 32'h1);
      else
        pulse(3'b010);
      rd(TMC_OFS_COUNT);
      check(32'(rdv[15:0]), 32'h0);
    end
    pulse(3'b001);
    rd(TMC_OFS_STATUS);
    check(32'(rdv[0]), 32'h0);
    $display("test update done");
  endtask

  task automatic t_single;
    wr(TMC_OFS_CTRL, 32'h9);
    repeat (60) @(posedge clk);
    rd(TMC_OFS_CTRL);
    check(rdv, 32'h8);
    $display("test single done");
  endtask

  task automatic t_slave;
    wr(TMC_OFS_SLAVE, 32'h6);
    wr(TMC_OFS_CTRL, 32'h0);
    pulse(3'b100);
    rd(TMC_OFS_CTRL);
    check(rdv, 32'h1);
    rd(TMC_OFS_STATUS);
    check(32'(rdv[2]), 32'h1);
    wr(TMC_OFS_CTRL, 32'h0);
    // Encoder direction up, so the reinit below clears the count
    e_up <= 1'b1;
    wr(TMC_OFS_SLAVE, 32'h5);
    wr(TMC_OFS_EVGEN, 32'h1);
    steps(3);
    rd(TMC_OFS_COUNT);
    check(32'(rdv[15:0]), 32'h0);
    wr(TMC_OFS_CTRL, 32'h11);
    steps(3);
    rd(TMC_OFS_COUNT);
    check(32'(rdv[15:0]), 32'h3);
    $display("test slave done");
  endtask

  // Counts and verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_edge;
    t_centre;
    t_update;
    t_single;
    t_slave;
    test_done;
  end

  // Watchdog
  initial begin
    repeat (8000) @(posedge clk);
    fails++;
    test_done;
  end
endmodule
